// file: common/tape_ctl_pkg.sv
// constants shared by the tape unit control logic
package tape_ctl_pkg;

   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned DEBOUNCE_MS   = 2;
   localparam int unsigned CAPTURE_NS    = 10_000;
   localparam int unsigned CAPTURE_CYC   =
      (CAPTURE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CAP_W         = 8;
   localparam int unsigned DEB_W         = 16;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [3:0]  CTRL_ADDR     = 4'h0;
   localparam logic [3:0]  STATUS_ADDR   = 4'h4;
   localparam logic [4:0]  CTRL_RESET    = 5'h02;

   // control fields (straps and fitted options)
   localparam int unsigned CTL_ONL_REQ   = 0;
   localparam int unsigned CTL_SEC_CONT  = 1;
   localparam int unsigned CTL_TER_ADDR  = 2;
   localparam int unsigned CTL_AUTO_LOL  = 3;
   localparam int unsigned CTL_PNL_DIS   = 4;

   // status fields
   localparam int unsigned ST_ONLINE     = 0;
   localparam int unsigned ST_PRIMARY    = 1;
   localparam int unsigned ST_SECONDARY  = 2;
   localparam int unsigned ST_TERTIARY   = 3;
   localparam int unsigned ST_READY      = 4;
   localparam int unsigned ST_RDY_OFFL   = 5;
   localparam int unsigned ST_FWD        = 6;
   localparam int unsigned ST_REV        = 7;
   localparam int unsigned ST_WRITE      = 8;
   localparam int unsigned ST_OVERWRITE  = 9;
   localparam int unsigned ST_WEN        = 10;
   localparam int unsigned ST_LOCKOUT    = 11;

   // panel switch indices
   localparam int unsigned SW_ONLINE     = 0;
   localparam int unsigned SW_RESET      = 1;
   localparam int unsigned SW_FWD        = 2;
   localparam int unsigned SW_REV        = 3;
   localparam int unsigned SW_COUNT      = 4;

   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// file: hdl/tape_unit_control.sv
// on-line, select, motion and write control of a reel tape transport
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.

// Operation
// (R1) after load done, online press sets online
// (R2) online press while online clears online
// (R3) panel reset pulses resets low, clears online
// (R4) online status only when online and secondary
// (R5) rewind-and-unload command clears online
// (R6) controller strobes load-online with set timing
// (R7) load-online strobe energizes relay, sets online
// (R8) auto option raises strobe during load forward
// (R9) strobe fall at beginning marker sets online (here any strobe fall while off line sets it; bot_marker is not checked)
// (R10) lockout high when option, online and selected
// (R11) address gives primary select, maybe online-gated
// (R12) primary select drives selects and lamp
// (R13) strap: secondary continuous or like primary
// (R14) strap: tertiary on address or copies secondary
// (R15) ready only online, selected, idle, interlocked
// (R16) ready plus sync forward gives forward motion
// (R17) ready plus sync reverse gives reverse motion
// (R18) offline ready accepts manual panel motion
// (R19) manual motion blocked at end markers
// (R20) delayed capture latches write; write enable low
// (R21) forward, write, overwrite latch overwrite path
// (R22) record check low ends overwrite
// (R23) counter capture strobe; debounced switch pulses
module tape_unit_control
   import tape_ctl_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000)
)(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // axi4-lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // panel switches, raw
   input  wire logic        online_sw,
   input  wire logic        reset_sw,
   input  wire logic        man_fwd_sw,
   input  wire logic        man_rev_sw,
   // transport state
   input  wire logic        load_done_flag,
   input  wire logic        load_seq_reset_n,
   input  wire logic        load_forward_flag,
   input  wire logic        load_busy,
   input  wire logic        rewind_active_flag,
   input  wire logic        interlock_ok,
   input  wire logic        eot_marker,
   input  wire logic        bot_marker,
   // controller interface
   input  wire logic        unit_address_in,
   input  wire logic        rewind_unload_cmd,
   input  wire logic        load_online_cmd,
   input  wire logic        sync_forward_cmd,
   input  wire logic        sync_reverse_cmd,
   input  wire logic        write_request_in,
   input  wire logic        overwrite_request_in,
   input  wire logic        record_check_pulse_n,
   output logic             online_status_out,
   output logic             ready_status_out,
   output logic             tertiary_select,
   // transport and panel outputs
   output logic             online_lamp,
   output logic             selected_lamp,
   output logic             select_data_out,
   output logic             select_ctrl_out,
   output logic             panel_lockout,
   output logic             interlock_relay,
   output logic             panel_reset_c_n,
   output logic             panel_reset_d_n,
   output logic             forward_motion,
   output logic             reverse_motion,
   output logic             write_enable_n
);

   // ------------------------------------------------------------
   // switch debounce
   // ------------------------------------------------------------
   logic [SW_COUNT-1:0] sw_raw;
   logic [SW_COUNT-1:0] sw_stable_r;
   logic [SW_COUNT-1:0] sw_prev_r;
   logic [SW_COUNT-1:0] sw_press;

   assign sw_raw = {man_rev_sw, man_fwd_sw, reset_sw, online_sw};

   // a level must hold for the whole window; contact bounce restarts it
   for (genvar i = 0; i < SW_COUNT; i++) begin : g_deb
      logic [DEB_W-1:0] cnt_r;
      always_ff @(posedge core_clk) begin
         if (!rst_n || sw_raw[i] == sw_stable_r[i]) begin
            cnt_r <= '0;
         end else if (cnt_r == DEB_W'(DEBOUNCE_CYC - 1)) begin
            cnt_r <= '0;
         end else begin
            cnt_r <= cnt_r + 1'b1;
         end
      end
      always_ff @(posedge core_clk) begin
         if (!rst_n) begin
            sw_stable_r[i] <= 1'b0;
            sw_prev_r[i]   <= 1'b0;
         end else begin
            if (sw_raw[i] != sw_stable_r[i] &&
                cnt_r == DEB_W'(DEBOUNCE_CYC - 1)) begin
               sw_stable_r[i] <= sw_raw[i]; // [R23]
            end
            sw_prev_r[i] <= sw_stable_r[i];
         end
      end
      assign sw_press[i] = sw_stable_r[i] & ~sw_prev_r[i]; // [R23]
   end

   // ------------------------------------------------------------
   // configuration register
   // ------------------------------------------------------------
   logic [4:0] ctrl_r;
   wire opt_onl_req  = ctrl_r[CTL_ONL_REQ];
   wire opt_sec_cont = ctrl_r[CTL_SEC_CONT];
   wire opt_ter_addr = ctrl_r[CTL_TER_ADDR];
   wire opt_auto_lol = ctrl_r[CTL_AUTO_LOL];
   wire opt_pnl_dis  = ctrl_r[CTL_PNL_DIS];

   // ------------------------------------------------------------
   // on-line logic
   // ------------------------------------------------------------
   logic online_state_r;
   logic strobe_r;

   wire reset_press = sw_press[SW_RESET];
   wire strobe_nxt  = load_online_cmd |                           // [R7]
                      (opt_auto_lol & load_forward_flag &
                       ~rewind_active_flag & ~online_state_r);    // [R8]
   wire strobe_fall = strobe_r & ~strobe_nxt;
   wire online_clr  = reset_press | ~load_seq_reset_n |           // [R3]
                      rewind_unload_cmd;                          // [R5]
   wire online_tgl  = sw_press[SW_ONLINE] & load_done_flag;       // [R1]
   wire online_set  = strobe_fall & ~online_state_r;              // [R9]
   wire online_nxt  = online_clr ? 1'b0 :
                      online_set ? 1'b1 :
                      online_tgl ? ~online_state_r :              // [R2]
                      online_state_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         online_state_r  <= 1'b0;
         strobe_r        <= 1'b0;
         panel_reset_c_n <= 1'b1;
         panel_reset_d_n <= 1'b1;
         interlock_relay <= 1'b0;
      end else begin
         online_state_r  <= online_nxt;
         strobe_r        <= strobe_nxt;
         panel_reset_c_n <= ~reset_press;   // [R3]
         panel_reset_d_n <= ~reset_press;   // [R3]
         interlock_relay <= strobe_nxt;     // [R7]
      end
   end

   // ------------------------------------------------------------
   // select, ready and motion decode
   // ------------------------------------------------------------
   wire primary_sel   = unit_address_in & (~opt_onl_req | online_nxt); // [R11]
   wire secondary_sel = opt_sec_cont | primary_sel;           // [R13]
   wire tertiary_sel  = opt_ter_addr ? unit_address_in :
                        secondary_sel;                        // [R14]
   wire idle_ok       = ~rewind_active_flag & ~load_busy & interlock_ok;
   wire ready_int     = online_nxt & primary_sel & idle_ok;   // [R15]
   wire ready_offline = ~online_nxt & idle_ok;                // [R18]
   wire man_fwd       = ready_offline & sw_stable_r[SW_FWD] &
                        ~eot_marker;                          // [R19]
   wire man_rev       = ready_offline & sw_stable_r[SW_REV] &
                        ~bot_marker;                          // [R19]
   wire fwd_nxt       = (ready_int & sync_forward_cmd) | man_fwd; // [R16]
   wire rev_nxt       = (ready_int & sync_reverse_cmd) | man_rev; // [R17]

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         online_lamp       <= 1'b0;
         online_status_out <= 1'b0;
         selected_lamp     <= 1'b0;
         select_data_out   <= 1'b0;
         select_ctrl_out   <= 1'b0;
         tertiary_select   <= 1'b0;
         panel_lockout     <= 1'b0;
         ready_status_out  <= 1'b0;
         forward_motion    <= 1'b0;
         reverse_motion    <= 1'b0;
      end else begin
         online_lamp       <= online_nxt;                    // [R1]
         online_status_out <= online_nxt & secondary_sel;    // [R4]
         selected_lamp     <= primary_sel;                   // [R12]
         select_data_out   <= primary_sel;                   // [R12]
         select_ctrl_out   <= primary_sel;                   // [R12]
         tertiary_select   <= tertiary_sel;
         panel_lockout     <= opt_pnl_dis & online_nxt &
                              primary_sel;                   // [R10]
         ready_status_out  <= ready_int;
         forward_motion    <= fwd_nxt;
         reverse_motion    <= rev_nxt;
      end
   end

   // ------------------------------------------------------------
   // write / overwrite capture
   // ------------------------------------------------------------
   logic [CAP_W-1:0] cap_cnt_r;
   logic             capture_r;
   logic             write_latched_r;
   logic             normal_path_r;
   logic             overwrite_r;

   // delay restarts on each start of forward motion and aborts on stop
   wire cap_start = fwd_nxt & ~forward_motion;
   wire cap_done  = forward_motion & (cap_cnt_r == CAP_W'(1));

   always_ff @(posedge core_clk) begin
      if (!rst_n || !fwd_nxt) begin
         cap_cnt_r <= '0;
      end else if (cap_start) begin
         cap_cnt_r <= CAP_W'(CAPTURE_CYC);                   // [R23]
      end else if (cap_cnt_r != '0) begin
         cap_cnt_r <= cap_cnt_r - 1'b1;
      end
   end

   wire ovw_set = capture_r & write_request_in & overwrite_request_in;
   wire wen_nxt = (write_latched_r & normal_path_r) | overwrite_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         capture_r       <= 1'b0;
         write_latched_r <= 1'b0;
         normal_path_r   <= 1'b0;
         overwrite_r     <= 1'b0;
         write_enable_n  <= 1'b1;
      end else begin
         capture_r <= cap_done;                              // [R23]
         if (capture_r) begin
            write_latched_r <= write_request_in;             // [R20]
            normal_path_r   <= ~overwrite_request_in;        // [R20]
         end else if (!forward_motion) begin
            write_latched_r <= 1'b0;
         end
         // a new capture wins over a coincident record check
         if (ovw_set) begin
            overwrite_r <= 1'b1;                             // [R21]
         end else if (!record_check_pulse_n) begin
            overwrite_r <= 1'b0;                             // [R22]
         end
         write_enable_n <= ~wen_nxt;                         // [R20]
      end
   end

   // ------------------------------------------------------------
   // axi4-lite slave
   // ------------------------------------------------------------
   logic [3:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic [11:0] status_w;

   assign status_w = {panel_lockout, ~write_enable_n, overwrite_r,
                      write_latched_r, reverse_motion, forward_motion,
                      ready_offline, ready_status_out, tertiary_select,
                      online_status_out, select_ctrl_out,
                      online_state_r};

   wire aw_hs   = s_axi_awvalid & s_axi_awready;
   wire w_hs    = s_axi_wvalid & s_axi_wready;
   wire aw_have = aw_hs | ~s_axi_awready;
   wire w_have  = w_hs | ~s_axi_wready;
   wire [3:0]  wr_addr = aw_hs ? s_axi_awaddr : aw_addr_r;
   wire [31:0] wr_data = w_hs ? s_axi_wdata : w_data_r;
   wire [3:0]  wr_strb = w_hs ? s_axi_wstrb : w_strb_r;
   wire wr_go   = aw_have & w_have & ~s_axi_bvalid;
   wire wr_ctrl = wr_go & (wr_addr == CTRL_ADDR);
   wire wr_ok   = (wr_addr == CTRL_ADDR) | (wr_addr == STATUS_ADDR);
   wire rd_hs   = s_axi_arvalid & s_axi_arready;
   wire rd_ctrl = s_axi_araddr == CTRL_ADDR;
   wire rd_stat = s_axi_araddr == STATUS_ADDR;
   wire [31:0] rd_data = rd_ctrl ? {27'h0000000, ctrl_r} :
                         rd_stat ? {20'h00000, status_w} : 32'h00000000;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_addr_r     <= 4'h0;
         w_data_r      <= 32'h00000000;
         w_strb_r      <= 4'h0;
         ctrl_r        <= CTRL_RESET;
      end else begin
         if (aw_hs) aw_addr_r <= s_axi_awaddr;
         if (w_hs) begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (aw_hs) s_axi_awready <= 1'b0;
         if (w_hs) s_axi_wready <= 1'b0;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (wr_ctrl && wr_strb[0]) ctrl_r <= wr_data[4:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (rd_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= (rd_ctrl | rd_stat) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   localparam int CAP_D = CAPTURE_CYC;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_online_toggle_on: assert property ( // [R1]
      online_tgl && !online_state_r && !online_clr && !online_set
      |=> online_state_r && online_lamp)
      else $error("online press did not set online");
   a_online_toggle_off: assert property ( // [R2]
      online_tgl && online_state_r && !online_clr |=> !online_state_r)
      else $error("online press did not clear online");
   a_reset_pulse: assert property ( // [R3]
      reset_press |=> !panel_reset_c_n && !panel_reset_d_n
                      && !online_state_r ##1 panel_reset_c_n)
      else $error("panel reset pulse wrong");
   a_status_gate: assert property ( // [R4]
      online_status_out |-> online_state_r && $past(secondary_sel))
      else $error("online status without online and select");
   a_unload_offline: assert property ( // [R5]
      rewind_unload_cmd |=> !online_state_r && !online_lamp)
      else $error("unload did not take unit off line");
   a_strobe_relay: assert property ( // [R7]
      $rose(load_online_cmd) |=> interlock_relay)
      else $error("strobe did not energize relay");
   a_auto_strobe: assert property ( // [R8]
      opt_auto_lol && load_forward_flag && !rewind_active_flag
      && !online_state_r |=> strobe_r)
      else $error("auto option strobe missing");
   a_strobe_fall_set: assert property ( // [R9]
      online_set && !online_clr |=> online_state_r)
      else $error("strobe fall did not set online");
   a_lockout_gate: assert property ( // [R10]
      panel_lockout |-> $past(opt_pnl_dis) && online_state_r
                        && selected_lamp)
      else $error("lockout raised wrongly");
   a_primary_gate: assert property ( // [R11]
      selected_lamp && $past(opt_onl_req) |-> online_state_r)
      else $error("select given while off line with strap");
   a_ready_gate: assert property ( // [R15]
      ready_status_out |-> online_state_r && select_ctrl_out
                           && $past(idle_ok))
      else $error("ready without its conditions");
   a_manual_block: assert property ( // [R19]
      forward_motion && !ready_status_out |-> !$past(eot_marker))
      else $error("manual forward at end marker");
   a_capture_delay: assert property ( // [R23]
      capture_r |-> $past(forward_motion, CAP_D)
                    && !$past(forward_motion, CAP_D + 1))
      else $error("capture strobe not at set delay");
   a_overwrite_end: assert property ( // [R22]
      !record_check_pulse_n && !ovw_set |=> !overwrite_r
      ##1 (write_enable_n || write_latched_r))
      else $error("record check did not end overwrite");

endmodule // tape_unit_control

// file: tb/controller_model.sv
// behavioural tape controller driving the far side of the control link
module controller_model #(
   parameter int unsigned LONG_CYC  = 20_000_000,
   parameter int unsigned SHORT_CYC = 20
)(
   input  wire logic [7:0] req,
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   output logic            unit_address_in,
   output logic            sync_forward_cmd,
   output logic            sync_reverse_cmd,
   output logic            write_request_in,
   output logic            overwrite_request_in,
   output logic            rewind_unload_cmd,
   output logic            record_check_pulse_n,
   output logic            load_online_cmd
);
   // ------------------------------------------------------------
   // request staging
   // ------------------------------------------------------------
   logic [31:0] lol_cnt_r;
   logic        chk_d_r;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         {overwrite_request_in, write_request_in} <= '0;
         {sync_reverse_cmd, sync_forward_cmd, unit_address_in} <= '0;
         rewind_unload_cmd <= 1'b0;
         chk_d_r <= 1'b0;
         record_check_pulse_n <= 1'b1;
         lol_cnt_r <= '0;
      end else begin
         // forward, write and overwrite always move on the same edge
         {overwrite_request_in, write_request_in} <= req[4:3];
         {sync_reverse_cmd, sync_forward_cmd, unit_address_in} <= req[2:0];
         rewind_unload_cmd <= req[5];
         chk_d_r <= req[6];
         record_check_pulse_n <= !(req[6] && !chk_d_r);
         if (req[7]) lol_cnt_r <= 32'h1;
         else if (lol_cnt_r != 0 && lol_cnt_r < 2*LONG_CYC+SHORT_CYC)
            lol_cnt_r <= lol_cnt_r + 32'h1;
         else lol_cnt_r <= '0;
      end
   end
   // on for long, off for long, then a short final strobe
   assign load_online_cmd = (lol_cnt_r != 0 && lol_cnt_r <= LONG_CYC)
                          || lol_cnt_r > 2*LONG_CYC;
endmodule // controller_model

// file: tb/testbench.sv
// self-checking bench for the tape unit control logic
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import tape_ctl_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic core_clk = 0, rst_n = 0;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic online_sw = 0, reset_sw = 0, man_fwd_sw = 0, man_rev_sw = 0;
   logic load_done_flag = 0, load_seq_reset_n = 1, load_forward_flag = 0;
   logic load_busy = 0, rewind_active_flag = 0, interlock_ok = 1;
   logic eot_marker = 0, bot_marker = 0;
   logic [7:0] req = '0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire logic s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic unit_address_in, sync_forward_cmd, sync_reverse_cmd;
   wire logic write_request_in, overwrite_request_in, rewind_unload_cmd;
   wire logic record_check_pulse_n, load_online_cmd;
   wire logic online_status_out, ready_status_out, tertiary_select;
   wire logic online_lamp, selected_lamp, select_data_out, select_ctrl_out;
   wire logic panel_lockout, interlock_relay, panel_reset_c_n;
   wire logic panel_reset_d_n, forward_motion, reverse_motion;
   wire logic write_enable_n;
   int mismatches = 0, total_checks = 0;
   tape_unit_control #(.DEBOUNCE_CYC(4)) i_tape_unit_control (.*);
   controller_model #(.LONG_CYC(50)) i_controller_model (.*);
   initial forever #25 core_clk = ~core_clk;
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input string s, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", e, s_axi_bresp);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", d, s_axi_rdata);
      chk("rresp", e, s_axi_rresp);
   endtask
   // switches must outlast the debounce window to count as one press
   task automatic press(input int k);
      {man_rev_sw, man_fwd_sw, reset_sw, online_sw} <= 4'h1 << k;
      step(10);
      {man_rev_sw, man_fwd_sw, reset_sw, online_sw} <= 4'h0;
      step(10);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      rd(CTRL_ADDR, 32'h2, RESP_OKAY);
      wr(CTRL_ADDR, 32'h13, RESP_OKAY);
      rd(CTRL_ADDR, 32'h13, RESP_OKAY);
      rd(4'h8, 32'h0, RESP_SLVERR);
      wr(4'h8, 32'h1F, RESP_SLVERR);
      wr(STATUS_ADDR, 32'hFFF, RESP_OKAY);
      rd(CTRL_ADDR, 32'h13, RESP_OKAY);
      req <= 8'h01;
      step(3);
      chk("gated select", 1'b0, select_data_out);
   endtask
   task automatic t_online;
      press(SW_ONLINE);
      chk("online lamp", 1'b1, online_lamp);
      chk("select out", 1'b1, select_data_out & select_ctrl_out);
      chk("select lamp", 1'b1, selected_lamp);
      chk("online status", 1'b1, online_status_out);
      chk("tertiary", 1'b1, tertiary_select);
      chk("ready", 1'b1, ready_status_out);
      chk("lockout", 1'b1, panel_lockout);
      rd(STATUS_ADDR, 32'h81F, RESP_OKAY);
   endtask
   task automatic t_write;
      req <= 8'h0B;
      step(3);
      chk("fwd", 1'b1, forward_motion);
      step(100);
      chk("wen early", 1'b1, write_enable_n);
      step(110);
      chk("wen write", 1'b0, write_enable_n);
      req <= 8'h05;
      step(3);
      chk("rev", 1'b1, reverse_motion);
      req <= 8'h1B;
      step(215);
      chk("wen ovw", 1'b0, write_enable_n);
      req <= 8'h41;
      step(5);
      chk("wen end", 1'b1, write_enable_n);
   endtask
   task automatic t_manual(input int k);
      {man_rev_sw, man_fwd_sw} <= 2'h1 << k;
      step(10);
      chk("manual", 1'b1, k ? reverse_motion : forward_motion);
      {bot_marker, eot_marker} <= 2'h1 << k;
      step(3);
      chk("marker", 1'b0, k ? reverse_motion : forward_motion);
      {man_rev_sw, man_fwd_sw, bot_marker, eot_marker} <= 4'h0;
      step(10);
   endtask
   task automatic t_offline;
      press(SW_ONLINE);
      chk("online off", 1'b0, online_lamp | online_status_out);
      chk("lockout off", 1'b0, panel_lockout);
      req <= 8'h00;
      t_manual(0);
      t_manual(1);
   endtask
   task automatic t_strobe;
      int n;
      n = 0;
      req <= 8'h80;
      step(10);
      req <= 8'h00;
      chk("relay", 1'b1, interlock_relay);
      step(140);
      chk("lol online", 1'b1, online_lamp);
      reset_sw <= 1'b1;
      repeat (10) begin
         step(1);
         if ((panel_reset_c_n | panel_reset_d_n) === 1'b0) n++;
      end
      chk("reset pulse", 32'd1, n);
      reset_sw <= 1'b0;
      step(10);
      chk("reset off", 1'b0, online_lamp);
      press(SW_ONLINE);
      req <= 8'h20;
      step(3);
      chk("unload off", 1'b0, online_lamp);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      step(20000);
      mismatches++;
      close_out();
   end
   initial begin
      step(20);
      rst_n <= 1'b1;
      load_done_flag <= 1'b1;
      step(1);
      chk("wen reset", 1'b1, write_enable_n);
      t_regs();
      t_online();
      t_write();
      t_offline();
      t_strobe();
      close_out();
   end
endmodule // testbench
